// ---- logic/dio_counter_pwm_port.sv ----
// Purpose: 48-line digital I/O with two counters and four modulators behind AXI4-Lite.
// Assumes: aclk 125 MHz; the 50 MHz board clock is an enable made from aclk.
// Notes: Byte registers sit in bits 7:0 of aligned words; upper bits read as zero.
// Notes on behaviour
// - 256 byte registers, 16 pages by function.
// - All accesses byte wide; wide values multi-byte.
// - 48 lines: five byte ports, eight bits.
// - One direction bit per byte port.
// - Bitwise port has per-bit direction register.
// - Enabled special function overrides direction and value.
// - Bits: gates, counter outputs, clocks, latch, ack.
// - Bits 3..0 may carry modulators 3..0.
// - Bitwise lines serve byte-port handshakes.
// - Reset: no functions, inputs, outputs zero.
// - Two independent 32-bit counter/timers.
// - Count source: 50 MHz, 1 MHz, external.
// - Optional gate line enables counting.
// - Optional counter output, selectable polarity.
// - Rate generator and external pulse counter.
// - Four 24-bit modulators, period and duty.
// - Period and duty writable while running.
// - Duty 0 to 100 percent, selectable polarity.
// - Modulator clock 50 MHz or 1 MHz.
// - Modulator reaches pin only when enabled.
// - Interrupts from both counters and I/O.
`timescale 1ns/100ps
`include "dio_port_cfg.svh"
module dio_counter_pwm_port import dio_port_pkg::*; #(
  parameter int CTR_W = 32,
  parameter int PWM_W = 24,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] byte_port_0_lines_in,
  output logic [7:0] byte_port_0_lines_out,
  output logic [7:0] byte_port_0_lines_oe_n,
  input wire logic [7:0] byte_port_1_lines_in,
  output logic [7:0] byte_port_1_lines_out,
  output logic [7:0] byte_port_1_lines_oe_n,
  input wire logic [7:0] byte_port_2_lines_in,
  output logic [7:0] byte_port_2_lines_out,
  output logic [7:0] byte_port_2_lines_oe_n,
  input wire logic [7:0] byte_port_3_lines_in,
  output logic [7:0] byte_port_3_lines_out,
  output logic [7:0] byte_port_3_lines_oe_n,
  input wire logic [7:0] byte_port_4_lines_in,
  output logic [7:0] byte_port_4_lines_out,
  output logic [7:0] byte_port_4_lines_oe_n,
  input wire logic [7:0] bitwise_port_lines_in,
  output logic [7:0] bitwise_port_lines_out,
  output logic [7:0] bitwise_port_lines_oe_n,
  output logic [2:0] irq_request
);
  // Bus holding registers; one write and one read at a time.
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_q;
  logic [7:0] w_q;
  logic wstrb0_q;
  // Host-written I/O state: output data (5 byte ports + bitwise), directions, handshake.
  logic [47:0] dout;
  logic [4:0] bdir;
  logic [7:0] fdir;
  logic [1:0] hs_ctl;
  logic [2:0] istat;
  // Three-flop input sampling; filt follows once the last two flops agree.
  logic [47:0] s1, s2, s3, filt, f_prev;
  logic [39:0] blatch;
  logic ack_q;
  // Registered pin drive.
  logic [39:0] bout, boe_n;
  logic [7:0] fout, foe_n;
  // Board-rate and microsecond enables.
  logic [27:0] acc;
  logic b50, us_tick;
  logic [5:0] pre;
  logic [31:0] hold;

  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire wr_fire = aw_full & w_full & ~bvalid;
  wire ar_take = arvalid & arready;
  wire next_aw_full = wr_fire ? 1'b0 : (aw_full | aw_take);
  wire next_w_full = wr_fire ? 1'b0 : (w_full | w_take);
  wire next_bvalid = wr_fire | (bvalid & ~bready);
  wire next_rvalid = ar_take | (rvalid & ~rready);
  // Addresses above the 256-register window answer with a decode error.
  wire wr_in = (aw_q[ADDR_W-1:10] == '0);
  wire rd_in = (araddr[ADDR_W-1:10] == '0);
  wire wr_en = wr_fire & wr_in & wstrb0_q;
  wire [7:0] widx = aw_q[9:2];
  wire [7:0] ridx = araddr[9:2];
  // Write decode; each register is a byte, wide values are several bytes.
  wire wsel_dout = wr_en && (widx < `DIO_BDIR);
  wire wsel_bdir = wr_en && (widx == `DIO_BDIR);
  wire wsel_fdir = wr_en && (widx == `DIO_FDIR);
  wire wsel_hs = wr_en && (widx == `DIO_HS_CTL);
  wire wsel_irq = wr_en && (widx == `DIO_IRQ_STAT);
  wire wsel_ctr = wr_en && (widx[7:4] == `CTR_PAGE);
  wire wsel_pwm = wr_en && (widx[7:5] == `PWM_PAGES);
  wire [47:0] next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  wire [7:0] f_filt = filt[47:40];
  wire [7:0] f_rise = f_filt & ~f_prev[47:40];
  wire latch_ev = hs_ctl[`HS_LATCH_BIT] & f_rise[6];
  wire [27:0] acc_sum = acc + `BOARD_HZ;

  // Per-channel results gathered from the generate loops.
  logic [2*CTR_W-1:0] cnt_all, load_all;
  logic [15:0] cctl_all;
  logic [1:0] ctr_tc, ctr_pin;
  logic [4*PWM_W-1:0] per_all, duty_all;
  logic [31:0] pctl_all;
  logic [3:0] pwm_raw;
  // Byte offered on the read channel, and the modulator index of a read.
  byte_t rd_byte;
  logic [1:0] rm;

  // AXI4-Lite handshakes; address and data may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h0;
      aw_q <= '0;
      w_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      awready <= ~next_aw_full & ~next_bvalid;
      wready <= ~next_w_full & ~next_bvalid;
      arready <= ~next_rvalid;
      if (aw_take) aw_q <= awaddr;
      if (w_take) begin
        w_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_fire) bresp <= wr_in ? 2'h0 : 2'h3;
      // Only the low byte carries data; the rest reads as zero.
      if (ar_take) begin
        rdata <= {24'h0, rd_byte};
        rresp <= rd_in ? 2'h0 : 2'h3;
      end
    end
  end

  // Read selection.
  always_comb begin
    rm = ridx[4:3];
    rd_byte = 8'h00;
    if (!rd_in) rd_byte = 8'h00;
    else if (ridx < `DIO_BDIR) rd_byte = dout[ridx[2:0]*8 +: 8];
    else if (ridx == `DIO_BDIR) rd_byte = {3'h0, bdir};
    else if (ridx == `DIO_FDIR) rd_byte = fdir;
    // Byte port inputs read latched data while the latch handshake is on.
    else if (ridx < `DIO_FIN) rd_byte = hs_ctl[`HS_LATCH_BIT] ?
      blatch[(ridx[2:0]-3'h0)*8 +: 8] : filt[(ridx[2:0])*8 +: 8];
    else if (ridx == `DIO_FIN) rd_byte = f_filt;
    else if (ridx == `DIO_HS_CTL) rd_byte = {6'h0, hs_ctl};
    else if (ridx == `DIO_IRQ_STAT) rd_byte = {5'h0, istat};
    // Counter byte 0 is live and snapshots the rest for bytes 1..3.
    else if (ridx[7:4] == `CTR_PAGE && ridx[2:0] == 3'h0)
      rd_byte = cnt_all[ridx[3]*CTR_W +: 8];
    else if (ridx[7:4] == `CTR_PAGE && ridx[2:0] < `CTR_CTL_OFS)
      rd_byte = hold[ridx[1:0]*8 +: 8];
    else if (ridx[7:4] == `CTR_PAGE && ridx[2:0] == `CTR_CTL_OFS)
      rd_byte = cctl_all[ridx[3]*8 +: 8];
    else if (ridx[7:5] == `PWM_PAGES && ridx[2:0] < `PWM_DUTY_OFS)
      rd_byte = per_all[rm*PWM_W + ridx[1:0]*8 +: 8];
    else if (ridx[7:5] == `PWM_PAGES && ridx[2:0] < `PWM_CTL_OFS)
      rd_byte = duty_all[rm*PWM_W + (ridx[2:0]-`PWM_DUTY_OFS)*8 +: 8];
    else if (ridx[7:5] == `PWM_PAGES && ridx[2:0] == `PWM_CTL_OFS)
      rd_byte = pctl_all[rm*8 +: 8];
  end

  // Snapshot so a 32-bit count read as four bytes stays coherent.
  always_ff @(posedge aclk) begin
    if (!aresetn) hold <= 32'h0;
    else if (ar_take && ridx[7:4] == `CTR_PAGE && ridx[2:0] == 3'h0)
      hold <= cnt_all[ridx[3]*CTR_W +: CTR_W];
  end

  // Host-written I/O registers; all clear on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 48'h0;
      bdir <= 5'h0;
      fdir <= `REG_RST;
      hs_ctl <= 2'h0;
    end else begin
      if (wsel_dout) dout[widx[2:0]*8 +: 8] <= w_q;
      if (wsel_bdir) bdir <= w_q[4:0];
      if (wsel_fdir) fdir <= w_q;
      if (wsel_hs) hs_ctl <= w_q[1:0];
    end
  end

  // Sticky requests: set wins over a write-one clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) istat <= 3'h0;
    else istat <= (istat & ~(wsel_irq ? w_q[2:0] : 3'h0)) | {latch_ev, ctr_tc};
  end
  assign irq_request = istat;

  // Input sampling and the strobe-latch / acknowledge handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 48'h0;
      s2 <= 48'h0;
      s3 <= 48'h0;
      filt <= 48'h0;
      f_prev <= 48'h0;
      blatch <= 40'h0;
      ack_q <= 1'b0;
    end else begin
      s1 <= {bitwise_port_lines_in, byte_port_4_lines_in, byte_port_3_lines_in,
        byte_port_2_lines_in, byte_port_1_lines_in, byte_port_0_lines_in};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      f_prev <= filt;
      if (latch_ev) blatch <= filt[39:0];
      ack_q <= latch_ev & hs_ctl[`HS_ACK_BIT];
    end
  end

  // Board-rate enable by fractional accumulation, then divide by 50.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 28'h0;
      b50 <= 1'b0;
      pre <= 6'h0;
      us_tick <= 1'b0;
    end else begin
      acc <= (acc_sum >= `ACLK_HZ) ? acc_sum - `ACLK_HZ : acc_sum;
      b50 <= acc_sum >= `ACLK_HZ;
      if (b50) pre <= (pre == `US_DIV - 6'h1) ? 6'h0 : pre + 6'h1;
      us_tick <= b50 && (pre == `US_DIV - 6'h1);
    end
  end

  // Two counter/timers.
  genvar c, m;
  generate
    for (c = 0; c < 2; c++) begin : g_ctr
      logic [CTR_W-1:0] load, cnt;
      logic [7:0] ctl;
      logic tog;
      ctr_src_t src;
      logic tick, tc;
      assign src = ctr_src_t'(ctl[`CTR_SRC_LSB +: 2]);
      // Source select and optional gate from the bitwise port.
      assign tick = ((src == SRC_BOARD) ? b50 : (src == SRC_US) ? us_tick :
        (src == SRC_EXT) ? f_rise[4+c] : 1'b0) &
        (~ctl[`CTR_GATE_BIT] | f_filt[c]);
      // Rate mode ends at 1 (divide by load); event mode wraps at all ones.
      assign tc = ctl[`CTR_RUN_BIT] & tick & (ctl[`CTR_EVT_BIT] ?
        (cnt == '1) : (cnt <= CTR_W'(1)));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          load <= '0;
          ctl <= `REG_RST;
          cnt <= '0;
          tog <= 1'b0;
        end else begin
          if (wsel_ctr && widx[3] == c && widx[2:0] < `CTR_CTL_OFS)
            load[widx[1:0]*8 +: 8] <= w_q;
          if (wsel_ctr && widx[3] == c && widx[2:0] == `CTR_CTL_OFS) ctl <= w_q;
          if (!ctl[`CTR_RUN_BIT]) cnt <= ctl[`CTR_EVT_BIT] ? '0 : load;
          else if (tc) cnt <= ctl[`CTR_EVT_BIT] ? '0 : load;
          else if (tick) cnt <= ctl[`CTR_EVT_BIT] ? cnt + CTR_W'(1) : cnt - CTR_W'(1);
          if (!ctl[`CTR_RUN_BIT]) tog <= 1'b0;
          else if (tc) tog <= ~tog;
        end
      end
      assign cnt_all[c*CTR_W +: CTR_W] = cnt;
      assign load_all[c*CTR_W +: CTR_W] = load;
      assign cctl_all[c*8 +: 8] = ctl;
      assign ctr_tc[c] = tc;
      assign ctr_pin[c] = tog ^ ctl[`CTR_NEG_BIT];
    end
    // Four modulators; staged values take effect at the next period start.
    for (m = 0; m < 4; m++) begin : g_pwm
      logic [PWM_W-1:0] per, duty, act_per, act_duty, pc;
      logic [7:0] ctl;
      logic raw, tick;
      assign tick = ctl[`PWM_SLOW_BIT] ? us_tick : b50;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          per <= '0;
          duty <= '0;
          act_per <= '0;
          act_duty <= '0;
          pc <= '0;
          ctl <= `REG_RST;
          raw <= 1'b0;
        end else begin
          if (wsel_pwm && widx[4:3] == m && widx[2:0] < `PWM_DUTY_OFS)
            per[widx[1:0]*8 +: 8] <= w_q;
          if (wsel_pwm && widx[4:3] == m && widx[2:0] >= `PWM_DUTY_OFS &&
            widx[2:0] < `PWM_CTL_OFS)
            duty[(widx[2:0]-`PWM_DUTY_OFS)*8 +: 8] <= w_q;
          if (wsel_pwm && widx[4:3] == m && widx[2:0] == `PWM_CTL_OFS) ctl <= w_q;
          if (!ctl[`PWM_RUN_BIT] || (tick && pc + PWM_W'(1) >= act_per)) begin
            pc <= '0;
            act_per <= per;
            act_duty <= duty;
          end else if (tick) pc <= pc + PWM_W'(1);
          // Duty 0 never high; duty at or above period always high.
          raw <= ctl[`PWM_RUN_BIT] & (pc < act_duty);
        end
      end
      assign per_all[m*PWM_W +: PWM_W] = per;
      assign duty_all[m*PWM_W +: PWM_W] = duty;
      assign pctl_all[m*8 +: 8] = ctl;
      assign pwm_raw[m] = raw ^ ctl[`PWM_NEG_BIT];
    end
  endgenerate

  // Bitwise port: plain direction first, special functions override it.
  logic [7:0] next_fdrv, next_fval;
  always_comb begin
    next_fdrv = fdir;
    next_fval = dout[47:40];
    for (int k = 0; k < 2; k++) begin
      if (cctl_all[k*8+`CTR_GATE_BIT]) next_fdrv[k] = 1'b0;
      if (cctl_all[k*8 +: 2] == 2'(SRC_EXT)) next_fdrv[4+k] = 1'b0;
      if (cctl_all[k*8+`CTR_OE_BIT]) begin
        next_fdrv[2+k] = 1'b1;
        next_fval[2+k] = ctr_pin[k];
      end
    end
    if (hs_ctl[`HS_LATCH_BIT]) next_fdrv[6] = 1'b0;
    if (hs_ctl[`HS_ACK_BIT]) begin
      next_fdrv[7] = 1'b1;
      next_fval[7] = ack_q;
    end
    // Modulators take bits 3..0 only when enabled onto them.
    for (int k = 0; k < 4; k++) begin
      if (pctl_all[k*8+`PWM_OE_BIT]) begin
        next_fdrv[k] = 1'b1;
        next_fval[k] = pwm_raw[k];
      end
    end
  end

  // Pin registers; reset leaves every line an input with zero data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bout <= 40'h0;
      boe_n <= {40{1'b1}};
      fout <= 8'h00;
      foe_n <= 8'hff;
    end else begin
      bout <= dout[39:0];
      for (int k = 0; k < 5; k++) boe_n[k*8 +: 8] <= {8{~bdir[k]}};
      fout <= next_fval;
      foe_n <= ~next_fdrv;
    end
  end
  assign byte_port_0_lines_out = bout[7:0];
  assign byte_port_1_lines_out = bout[15:8];
  assign byte_port_2_lines_out = bout[23:16];
  assign byte_port_3_lines_out = bout[31:24];
  assign byte_port_4_lines_out = bout[39:32];
  assign byte_port_0_lines_oe_n = boe_n[7:0];
  assign byte_port_1_lines_oe_n = boe_n[15:8];
  assign byte_port_2_lines_oe_n = boe_n[23:16];
  assign byte_port_3_lines_oe_n = boe_n[31:24];
  assign byte_port_4_lines_oe_n = boe_n[39:32];
  assign bitwise_port_lines_out = fout;
  assign bitwise_port_lines_oe_n = foe_n;

  // Checks; helper gap counts aclk cycles between microsecond ticks.
  logic [7:0] gap;
  logic seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 8'h0;
      seen <= 1'b0;
    end else begin
      gap <= us_tick ? 8'h0 : gap + 8'h1;
      if (us_tick) seen <= 1'b1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence latch_seen;
    latch_ev && hs_ctl[`HS_ACK_BIT];
  endsequence
  sequence ack_shown;
    ack_q ##1 (!foe_n[7] && fout[7]);
  endsequence
  a_byte_wide_read: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_us_spacing: assert property (us_tick && seen |-> gap == `US_ACLK_CYCLES - 8'h1)
    else $error("microsecond tick spacing wrong");
  a_board_rate: assert property (b50 |=> !b50)
    else $error("board rate enable too fast");
  a_reset_inputs: assert property ($rose(aresetn) |->
    foe_n == 8'hff && &boe_n && fout == 8'h0)
    else $error("lines not inputs after reset");
  a_gate_input: assert property (cctl_all[8+`CTR_GATE_BIT] && !pctl_all[8+`PWM_OE_BIT] |=>
    foe_n[1])
    else $error("gate line not released");
  a_pwm_pin: assert property (pctl_all[`PWM_OE_BIT] |=> !foe_n[0] && fout[0] == $past(pwm_raw[0]))
    else $error("modulator not on pin");
  a_full_duty: assert property (g_pwm[0].ctl[`PWM_RUN_BIT] && g_pwm[0].act_duty >= g_pwm[0].act_per
    && $stable(g_pwm[0].act_duty) |=> g_pwm[0].raw)
    else $error("full duty not held high");
  a_irq_sticky: assert property (istat[0] && !(wsel_irq && w_q[0]) |=> istat[0])
    else $error("request dropped without clear");
  a_set_wins: assert property (ctr_tc[0] |=> istat[0])
    else $error("counter event lost");
  a_rate_reload: assert property (ctr_tc[0] && !cctl_all[`CTR_EVT_BIT] |=>
    cnt_all[31:0] == $past(load_all[31:0]))
    else $error("rate reload wrong");
  a_latch_ack: assert property (latch_seen |=> ack_shown)
    else $error("acknowledge not shown");
  a_dir_unison: assert property (bdir[2] |=> byte_port_2_lines_oe_n == 8'h00)
    else $error("byte port not driven");
endmodule // dio_counter_pwm_port

// ---- logic/dio_port_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the I/O block.
// Assumes: Register index = byte address / 4; one byte register per word.
// Notes: Page = index[7:4], register within page = index[3:0].
`ifndef DIO_PORT_CFG_SVH
`define DIO_PORT_CFG_SVH
`define DIO_OUT_BASE 8'h00
`define DIO_BDIR 8'h06
`define DIO_FDIR 8'h07
`define DIO_IN_BASE 8'h08
`define DIO_FIN 8'h0d
`define DIO_HS_CTL 8'h0e
`define DIO_IRQ_STAT 8'h0f
`define CTR_PAGE 4'h1
`define CTR_CTL_OFS 3'h4
`define PWM_PAGES 3'h1
`define PWM_DUTY_OFS 3'h3
`define PWM_CTL_OFS 3'h6
`define CTR_SRC_LSB 0
`define CTR_GATE_BIT 2
`define CTR_OE_BIT 3
`define CTR_NEG_BIT 4
`define CTR_EVT_BIT 5
`define CTR_RUN_BIT 6
`define PWM_RUN_BIT 0
`define PWM_SLOW_BIT 1
`define PWM_NEG_BIT 2
`define PWM_OE_BIT 3
`define HS_LATCH_BIT 0
`define HS_ACK_BIT 1
`define REG_RST 8'h00
`define ACLK_HZ 28'd125000000
`define BOARD_HZ 28'd50000000
`define US_DIV 6'd50
`define US_ACLK_CYCLES 8'd125
`endif

// ---- logic/dio_port_pkg.sv ----
// Purpose: Types shared by the I/O block.
// Assumes: Nothing beyond the cfg header.
// Notes: Field positions live in the cfg header.
package dio_port_pkg;
  // Count source of a counter, held in its control byte.
  typedef enum logic [1:0] {SRC_BOARD, SRC_US, SRC_EXT, SRC_SPARE} ctr_src_t;
  // One host-visible register.
  typedef logic [7:0] byte_t;
endpackage

// ---- tb/pin_model.sv ----
// Purpose: Outside world of one 8-bit port: pull-ups plus an optional outside driver.
// Assumes: Lines are pulled up when nobody drives them.
// Notes: The block's own drive wins over the outside driver.
`timescale 1ns/100ps
module pin_model (
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] drv,
  input wire logic [7:0] den,
  output logic [7:0] pin
);
  // Resolve each wire; a released line never keeps its old value, it floats up.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      pin[b] = !oe_n[b] ? out[b] : (den[b] ? drv[b] : 1'b1);
    end
  end
endmodule // pin_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the 48-line I/O block.
// Assumes: Byte address is four times the register index.
// Notes: Each scenario task drives the block and judges what comes back.
`timescale 1ns/100ps
`include "dio_port_cfg.svh"
module tb;
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] irq_request;
  // Port arrays: index 5 is the bitwise port.
  logic [7:0] po [6], poe [6], pi [6], drv [6], den [6];
  int errors = 0, compares = 0, cyc = 0;
  dio_counter_pwm_port dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq_request(irq_request),
    .byte_port_0_lines_in(pi[0]), .byte_port_0_lines_out(po[0]), .byte_port_0_lines_oe_n(poe[0]),
    .byte_port_1_lines_in(pi[1]), .byte_port_1_lines_out(po[1]), .byte_port_1_lines_oe_n(poe[1]),
    .byte_port_2_lines_in(pi[2]), .byte_port_2_lines_out(po[2]), .byte_port_2_lines_oe_n(poe[2]),
    .byte_port_3_lines_in(pi[3]), .byte_port_3_lines_out(po[3]), .byte_port_3_lines_oe_n(poe[3]),
    .byte_port_4_lines_in(pi[4]), .byte_port_4_lines_out(po[4]), .byte_port_4_lines_oe_n(poe[4]),
    .bitwise_port_lines_in(pi[5]), .bitwise_port_lines_out(po[5]),
    .bitwise_port_lines_oe_n(poe[5]));
  for (genvar k = 0; k < 6; k++) begin : pins
    pin_model p_u (.out(po[k]), .oe_n(poe[k]), .drv(drv[k]), .den(den[k]), .pin(pi[k]));
  end
  // 125 MHz clock and a free cycle count for timing spans.
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // One byte write; each channel is held until its own ready is seen.
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!(bvalid && bready) && n < 200);
    bready <= 0;
    if (n == 200) errors++;
    chk(bresp, er);
  endtask
  // One byte read; data and response are taken at the handshake edge.
  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
    end while (!(rvalid && rready) && n < 200);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (n == 200) errors++;
  endtask
  task automatic rdchk(input logic [9:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, {24'h0, e});
    chk(r, 2'h0);
  endtask
  // Bitwise-port bit must hold one level for n cycles.
  task automatic hold(input int b, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge aclk);
      if (po[5][b] !== v) bad++;
    end
    chk(bad, 0);
  endtask
  // Waits until bitwise output bit b changes, bounded.
  task automatic flip(input int b);
    logic v;
    int n;
    v = po[5][b];
    n = 0;
    while (po[5][b] === v && n < 400) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic span(input int b, input int exp);
    int t0;
    flip(b);
    t0 = cyc;
    flip(b);
    chk(cyc - t0, exp);
  endtask
  task automatic reset_chk();
    aresetn <= 0;
    tick(20);
    aresetn <= 1;
    tick(2);
    for (int p = 0; p < 6; p++) begin
      chk(poe[p], 8'hff);
      chk(po[p], 8'h00);
    end
    chk(irq_request, 3'h0);
  endtask
  // Each byte port turns all eight lines around together; inputs read back.
  task automatic t_bytes();
    for (int p = 0; p < 5; p++) begin
      wr(p, 8'h11 * (p + 1));
      wr(`DIO_BDIR, 8'h01 << p);
      tick(2);
      for (int q = 0; q < 6; q++) chk(poe[q], (q == p) ? 8'h00 : 8'hff);
      chk(po[p], 8'h11 * (p + 1));
      drv[p] <= 8'h30 + p;
      den[p] <= 8'hff;
    end
    wr(`DIO_BDIR, 8'h00);
    tick(8);
    for (int p = 0; p < 5; p++) rdchk(`DIO_IN_BASE + p, 8'h30 + p);
    rdchk(2, 8'h33);
  endtask
  task automatic t_bits();
    wr(5, 8'ha5);
    wr(`DIO_FDIR, 8'h3c);
    tick(2);
    chk(poe[5], 8'hc3);
    chk(po[5] & 8'h3c, 8'h24);
    chk(poe[0], 8'hff);
  endtask
  // Modulators take over F0-F3 against a programmed output of 0.
  task automatic t_pwm();
    wr(5, 8'h00);
    wr(`DIO_FDIR, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      wr(8'h20 + 8 * m, 8'h04);
      wr(8'h23 + 8 * m, 8'h04);
      wr(8'h26 + 8 * m, 8'h09);
      tick(20);
      chk(poe[5][m], 1'b0);
      hold(m, 1'b1, 16);
      wr(8'h26 + 8 * m, 8'h0d);
      tick(20);
      hold(m, 1'b0, 16);
      wr(8'h23 + 8 * m, 8'h00);
      tick(20);
      hold(m, 1'b1, 16);
      wr(8'h26 + 8 * m, 8'h05);
      tick(4);
      hold(m, 1'b0, 8);
    end
    wr(`DIO_FDIR, 8'h00);
  endtask
  // Rate generator spans at both clocks, polarity, sticky terminal request.
  task automatic t_ctr();
    logic lvl;
    wr(8'h10, 8'h04);
    wr(8'h14, 8'h48);
    tick(4);
    span(2, 10);
    chk(poe[5][2], 1'b0);
    chk(irq_request[0], 1'b1);
    wr(8'h14, 8'h08);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h49);
    span(2, 125);
    wr(8'h14, 8'h08);
    tick(4);
    lvl = po[5][2];
    wr(8'h14, 8'h18);
    tick(2);
    chk(po[5][2], !lvl);
    wr(8'h14, 8'h00);
    tick(20);
    chk(irq_request[0], 1'b1);
    wr(`DIO_IRQ_STAT, 8'h01);
    tick(2);
    chk(irq_request[0], 1'b0);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      drv[5][5] <= 1'b1;
      tick(8);
      drv[5][5] <= 1'b0;
      tick(8);
    end
  endtask
  // External pulses on F5 counted only while the F1 gate is high.
  task automatic t_evt();
    den[5] <= 8'h22;
    drv[5] <= 8'h00;
    wr(8'h1c, 8'h66);
    tick(8);
    pulses(2);
    drv[5] <= 8'h02;
    tick(8);
    pulses(3);
    rdchk(8'h18, 8'h03);
    rdchk(8'h19, 8'h00);
    wr(8'h1c, 8'h00);
  endtask
  // F6 rise latches the byte-port inputs and raises the I/O request.
  task automatic t_latch();
    logic [31:0] d;
    logic [1:0] r;
    wr(`DIO_HS_CTL, 8'h01);
    den[5] <= 8'h40;
    drv[5] <= 8'h00;
    drv[2] <= 8'h5a;
    tick(8);
    drv[5] <= 8'h40;
    tick(8);
    drv[2] <= 8'hff;
    tick(8);
    rdchk(`DIO_IN_BASE + 2, 8'h5a);
    chk(irq_request[2], 1'b1);
    wr(`DIO_IRQ_STAT, 8'h04);
    tick(2);
    chk(irq_request[2], 1'b0);
    wr(`DIO_HS_CTL, 8'h03);
    tick(2);
    chk(poe[5][7], 1'b0);
    drv[5] <= 8'h00;
    tick(8);
    drv[5] <= 8'h40;
    tick(8);
    chk(irq_request[2], 1'b1);
    wr(10'h100, 8'h5a, 2'h3);
    rd(10'h100, d, r);
    chk(d, 32'h0);
    chk(r, 2'h3);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs well under 10000 cycles.
  initial begin
    #400us;
    errors++;
    final_report();
  end
  initial begin
    for (int p = 0; p < 6; p++) begin
      drv[p] = 8'h00;
      den[p] = 8'h00;
    end
    reset_chk();
    t_bytes();
    t_bits();
    t_pwm();
    t_ctr();
    t_evt();
    t_latch();
    wr(8'h26, 8'h09);
    reset_chk();
    final_report();
  end
endmodule // tb
